// [fper_pkg.sv]
// constants for the flash program/erase register block
package fper_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_OPTION_KEY   = 8'h08;
  localparam logic [7:0] OFF_STATUS       = 8'h0c;
  localparam logic [7:0] OFF_CONTROL      = 8'h10;
  localparam logic [7:0] OFF_ADDRESS      = 8'h14;
  localparam logic [7:0] OFF_OPTION_IMAGE = 8'h1c;
  localparam logic [7:0] OFF_WP_IMAGE     = 8'h20;
  localparam logic [7:0] OFF_BANK2_KEY    = 8'h44;
  localparam logic [7:0] OFF_UNLOCK_KEY   = 8'h04;
  // status fields
  localparam int SR_BUSY      = 0;
  localparam int SR_NOT_ERASE = 2;
  localparam int SR_PROTECT   = 4;
  localparam int SR_DONE      = 5;
  // control fields
  localparam int CR_PROGRAM   = 0;
  localparam int CR_PAGE_ER   = 1;
  localparam int CR_MASS_ER   = 2;
  localparam int CR_OPT_PG    = 4;
  localparam int CR_OPT_ER    = 5;
  localparam int CR_START     = 6;
  localparam int CR_LOCK      = 7;
  localparam int CR_OPT_WREN  = 9;
  localparam int CR_ERR_IE    = 10;
  localparam int CR_DONE_IE   = 12;
  localparam logic [31:0] CR_WRITABLE = 32'h0000_1677;
  // reset values
  localparam logic [31:0] RST_CONTROL = 32'h0000_0080;
  localparam logic [31:0] RST_STATUS  = 32'h0000_0000;
  localparam logic [31:0] RST_ADDRESS = 32'h0000_0000;
  localparam logic [31:0] RST_OPTION  = 32'h03ff_fffc;
  localparam logic [31:0] RST_WP      = 32'hffff_ffff;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [15:0] ERASED_HALF = 16'hffff;
  // key values are not published here; arbitrary neutral defaults
  localparam logic [31:0] KEY_FIRST   = 32'h1111_2222;
  localparam logic [31:0] KEY_SECOND  = 32'h3333_4444;
  // information block words: user/rdp, data, wp0/1, wp2/3
  localparam int INFO_WORDS = 4;
  localparam logic [7:0] RDP_OPEN = 8'ha5;
  // flash operation duration in system clocks
  localparam int OP_TIME_NS = 2000;
  localparam int CLK_NS     = 20;
  localparam int OP_CYCLES  = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {FPER_IDLE, FPER_LOAD, FPER_BUSY} fper_state_t;
endpackage : fper_pkg

// [fper_regs.sv]
// flash program/erase register block with wishbone slave and option loader
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
module fper_regs
  import fper_pkg::*;
#(
  parameter int OP_LEN = OP_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // information block, one word per address
  output logic      [1:0]  info_addr,
  input  wire logic [31:0] info_data,
  // flash array status for the current target
  input  wire logic        target_protected,
  input  wire logic        target_erased,
  // interrupt and bank two key strobe
  output logic             irq,
  output logic             bank2_key_wr,
  output logic      [31:0] bank2_key_data
);
  import fper_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  fper_state_t state;
  logic [31:0] control;
  logic [5:0]  status;
  logic [31:0] target_address;
  logic [31:0] option_image;
  logic [31:0] protect_bits;
  logic [1:0]  key_stage;
  logic        unlock_dead;
  logic [1:0]  opt_stage;
  logic        opt_dead;
  logic [15:0] op_count;
  logic [1:0]  load_idx;
  logic        mismatch_acc;

  // a byte pair is good if erased or complementary
  function automatic logic pair_bad(input logic [15:0] w);
    pair_bad = !(w == ERASED_HALF) && (w[15:8] != ~w[7:0]);
  endfunction : pair_bad
  function automatic logic [7:0] pair_val(input logic [15:0] w);
    pair_val = pair_bad(w) ? ERASED_BYTE : w[7:0];
  endfunction : pair_val

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; byte and half-word writes are ignored but acknowledged, reads return the whole word
  wire         req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire         full_wr  = req && wb_we_i && (wb_sel_i == 4'hf);
  wire         wr_key   = full_wr && wb_adr_i == OFF_UNLOCK_KEY;
  wire         wr_okey  = full_wr && wb_adr_i == OFF_OPTION_KEY;
  wire         wr_sr    = full_wr && wb_adr_i == OFF_STATUS;
  wire         wr_cr    = full_wr && wb_adr_i == OFF_CONTROL;
  wire         wr_ar    = full_wr && wb_adr_i == OFF_ADDRESS;
  wire         wr_k2    = full_wr && wb_adr_i == OFF_BANK2_KEY;
  wire         locked   = control[CR_LOCK];
  wire         busy     = status[SR_BUSY];
  wire         cr_open  = !locked && state != FPER_LOAD;
  wire         key_ok   = (key_stage == 2'd0) ? (wb_dat_i == KEY_FIRST)
                                               : (wb_dat_i == KEY_SECOND);
  wire         okey_ok  = (opt_stage == 2'd0) ? (wb_dat_i == KEY_FIRST)
                                               : (wb_dat_i == KEY_SECOND);
  wire         sel_any  = |{control[CR_OPT_ER], control[CR_OPT_PG],
                            control[CR_MASS_ER], control[CR_PAGE_ER]};
  wire         go_erase = wr_cr && cr_open && !busy && wb_dat_i[CR_START]
                          && sel_any;
  // program starts on the address write; the start bit stays an erase trigger
  wire         go_prog  = wr_ar && !busy && !locked && control[CR_PROGRAM]
                          && state == FPER_IDLE;
  wire         op_end   = state == FPER_BUSY && op_count == 16'd0;
  wire         err_end  = state == FPER_BUSY && control[CR_PROGRAM]
                          && (target_protected || !target_erased);
  wire         finish   = op_end || err_end;
  wire [31:0]  sr_word  = {26'h0, status};
  wire [31:0]  rd_mux   = (wb_adr_i == OFF_STATUS)       ? sr_word :
                          (wb_adr_i == OFF_CONTROL)      ? control :
                          (wb_adr_i == OFF_OPTION_IMAGE) ? option_image :
                          (wb_adr_i == OFF_WP_IMAGE)     ? protect_bits :
                          32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one cycle after the request is seen
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0;
    end
  end

  // bank two keys pass straight to the second controller
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bank2_key_wr   <= 1'b0;
      bank2_key_data <= 32'h0;
    end else begin
      bank2_key_wr   <= wr_k2;
      bank2_key_data <= wr_k2 ? wb_dat_i : bank2_key_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option loader runs after each reset before software may operate
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= FPER_LOAD;
      load_idx     <= 2'd0;
      mismatch_acc <= 1'b0;
      option_image <= RST_OPTION;
      protect_bits <= RST_WP;
      op_count     <= 16'd0;
    end else begin
      unique case (state)
        FPER_LOAD: begin
          load_idx <= load_idx + 2'd1;
          unique case (load_idx)
            2'd0: begin
              option_image[9:2] <= pair_val(info_data[15:0]);
              // protection has its own pair, so the user bits stay without effect
              option_image[1]   <= (info_data[31:16] != {~RDP_OPEN, RDP_OPEN});
              mismatch_acc      <= pair_bad(info_data[15:0]);
            end
            2'd1: begin
              option_image[17:10] <= pair_val(info_data[15:0]);
              option_image[25:18] <= pair_val(info_data[31:16]);
              mismatch_acc        <= mismatch_acc | pair_bad(info_data[15:0])
                                     | pair_bad(info_data[31:16]);
            end
            2'd2: begin
              protect_bits[7:0]  <= pair_val(info_data[15:0]);
              protect_bits[15:8] <= pair_val(info_data[31:16]);
              mismatch_acc       <= mismatch_acc | pair_bad(info_data[15:0])
                                    | pair_bad(info_data[31:16]);
            end
            2'd3: begin
              protect_bits[23:16] <= pair_val(info_data[15:0]);
              protect_bits[31:24] <= pair_val(info_data[31:16]);
              option_image[0]     <= mismatch_acc | pair_bad(info_data[15:0])
                                     | pair_bad(info_data[31:16]);
              state               <= FPER_IDLE;
            end
          endcase
        end
        FPER_IDLE: begin
          if (go_erase || go_prog) begin
            state    <= FPER_BUSY;
            op_count <= OP_LEN[15:0];
          end
        end
        FPER_BUSY: begin
          op_count <= op_count - 16'd1;
          if (finish) begin
            state <= FPER_IDLE;
          end
        end
      endcase
    end
  end
  assign info_addr = load_idx;

  ////////////////////////////////////////////////////////////////////////////
  // a program operation starts when software writes the target address
  wire prog_start = go_prog;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      target_address <= RST_ADDRESS;
    end else if (wr_ar && !busy) begin
      target_address <= wb_dat_i;
    end
  end

  // status flags: a hardware set wins over a same-cycle clear
  wire set_done = op_end && !err_end;
  wire set_prot = err_end && target_protected;
  wire set_nerr = err_end && !target_protected && !target_erased;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status <= RST_STATUS[5:0];
    end else begin
      status[SR_DONE] <= set_done
                         || (status[SR_DONE] && !(wr_sr && wb_dat_i[SR_DONE]));
      status[SR_PROTECT] <= set_prot
                         || (status[SR_PROTECT] && !(wr_sr && wb_dat_i[SR_PROTECT]));
      status[SR_NOT_ERASE] <= set_nerr
                         || (status[SR_NOT_ERASE] && !(wr_sr && wb_dat_i[SR_NOT_ERASE]));
      status[SR_BUSY] <= (busy && !finish) || go_erase || prog_start;
      status[3]       <= 1'b0;
      status[1]       <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequencing; a wrong unlock key kills the unlock path, a wrong option key the option path, until reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      key_stage   <= 2'd0;
      unlock_dead <= 1'b0;
      opt_stage   <= 2'd0;
      opt_dead    <= 1'b0;
    end else begin
      if (wr_key && locked && !unlock_dead) begin
        key_stage   <= key_ok ? key_stage + 2'd1 : 2'd0;
        unlock_dead <= !key_ok;
      end else if (!locked) begin
        key_stage <= 2'd0;
      end
      if (wr_okey && !locked && !opt_dead) begin
        opt_stage <= okey_ok ? opt_stage + 2'd1 : 2'd0;
        opt_dead  <= !okey_ok;
      end else if (control[CR_OPT_WREN]) begin
        opt_stage <= 2'd0;
      end
    end
  end
  wire unlock_hit = wr_key && locked && !unlock_dead && key_ok && key_stage == 2'd1;
  wire opt_hit    = wr_okey && !locked && !opt_dead && okey_ok && opt_stage == 2'd1;

  // control register; lock only accepts a one from software
  wire [31:0] cr_wr = (control & ~CR_WRITABLE) | (wb_dat_i & CR_WRITABLE);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      control <= RST_CONTROL;
    end else begin
      if (wr_cr && cr_open) begin
        control <= cr_wr;
        control[CR_OPT_WREN] <= control[CR_OPT_WREN] && wb_dat_i[CR_OPT_WREN];
        control[CR_LOCK]     <= wb_dat_i[CR_LOCK];
        control[CR_START]    <= (control[CR_START] || wb_dat_i[CR_START]) && !finish;
      end else begin
        if (wr_cr && wb_dat_i[CR_LOCK]) begin
          control[CR_LOCK] <= 1'b1;
        end else if (unlock_hit) begin
          control[CR_LOCK] <= 1'b0;
        end
        if (opt_hit) begin
          control[CR_OPT_WREN] <= 1'b1;
        end
        if (finish) begin
          control[CR_START] <= 1'b0;
        end
      end
    end
  end

  // one interrupt line for both enabled causes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= (control[CR_DONE_IE] && status[SR_DONE])
             || (control[CR_ERR_IE] && (status[SR_PROTECT] || status[SR_NOT_ERASE]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_key_reads_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    (req && !wb_we_i && wb_adr_i == OFF_OPTION_KEY) |=> wb_dat_o == 32'h0)
    else $error("option key read not zero");
  a_done_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_sr && wb_dat_i[SR_DONE] && !set_done) |=> !status[SR_DONE])
    else $error("done flag not cleared");
  a_done_only_ok: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(status[SR_DONE]) |-> $past(op_end && !err_end))
    else $error("done flag set without success");
  a_prot_set: assert property (@(posedge mclk) disable iff (!rst_b)
    set_prot |=> status[SR_PROTECT] && !busy)
    else $error("protect flag missing");
  a_nerr_set: assert property (@(posedge mclk) disable iff (!rst_b)
    set_nerr |=> status[SR_NOT_ERASE])
    else $error("not erased flag missing");
  a_busy_erase: assert property (@(posedge mclk) disable iff (!rst_b)
    go_erase |=> busy [*2])
    else $error("busy not held after start");
  a_irq_done: assert property (@(posedge mclk) disable iff (!rst_b)
    (control[CR_DONE_IE] && status[SR_DONE]) |=> irq)
    else $error("done irq missing");
  a_irq_err: assert property (@(posedge mclk) disable iff (!rst_b)
    (!control[CR_ERR_IE] && !control[CR_DONE_IE]) |=> !irq)
    else $error("irq without enable");
  a_lock_stays: assert property (@(posedge mclk) disable iff (!rst_b)
    (unlock_dead && locked) |=> locked)
    else $error("lock cleared after failed unlock");
  a_start_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(busy) |-> !control[CR_START])
    else $error("start not cleared with busy");
  a_addr_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_ar && busy) |=> $stable(target_address))
    else $error("address written while busy");
  // sequencing checks; the bench sees most of these effects only through the bus, irq and the bank two strobe directly
  a_prog_busy: assert property (@(posedge mclk) disable iff (!rst_b)
    go_prog |=> busy)
    else $error("busy not raised by program start");
  a_busy_ends: assert property (@(posedge mclk) disable iff (!rst_b)
    finish |=> !busy)
    else $error("busy held after operation end");
  a_done_set: assert property (@(posedge mclk) disable iff (!rst_b)
    set_done |=> status[SR_DONE])
    else $error("done flag missing after success");
  a_no_done_err: assert property (@(posedge mclk) disable iff (!rst_b)
    (err_end && !status[SR_DONE]) |=> !status[SR_DONE])
    else $error("done flag set on failed program");
  a_irq_err_on: assert property (@(posedge mclk) disable iff (!rst_b)
    (control[CR_ERR_IE] && (status[SR_PROTECT] || status[SR_NOT_ERASE])) |=> irq)
    else $error("error irq missing");
  a_lock_kept: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_cr && locked && !wb_dat_i[CR_LOCK]) |=> locked)
    else $error("locked control accepted a clear");
  a_key_kill: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_key && locked && !key_ok) |=> unlock_dead)
    else $error("wrong key did not end unlocking");
  a_opt_wren_set: assert property (@(posedge mclk) disable iff (!rst_b)
    opt_hit |=> control[CR_OPT_WREN])
    else $error("option write enable not set by keys");
  a_images_fixed: assert property (@(posedge mclk) disable iff (!rst_b)
    (state != FPER_LOAD) |=> ($stable(protect_bits) && $stable(option_image)))
    else $error("image changed outside loading");
  a_bank2_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    bank2_key_wr |=> !bank2_key_wr)
    else $error("bank two strobe longer than one cycle");
  a_ack_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    !wb_ack_o |-> (wb_dat_o == 32'h0))
    else $error("read data outside ack");

  ////////////////////////////////////////////////////////////////////////////
  // covers for the main scenarios
  c_erase_done: cover property (@(posedge mclk) disable iff (!rst_b)
    go_erase ##[1:200] set_done);
  c_unlock: cover property (@(posedge mclk) disable iff (!rst_b) unlock_hit);
  c_opt_wren: cover property (@(posedge mclk) disable iff (!rst_b) opt_hit);
  c_prot_err: cover property (@(posedge mclk) disable iff (!rst_b) set_prot);
  c_not_erased: cover property (@(posedge mclk) disable iff (!rst_b) set_nerr);
endmodule : fper_regs

// [tb_top.sv]
// self-checking testbench for the flash program/erase register block
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module tb_top;
  import fper_pkg::*;
  // short operation keeps the run brief
  localparam int          OPL     = 8;
  localparam int          LIMIT   = 20000;
  // user_byte_hi pair is corrupted on purpose, so it loads as 0xff with the mismatch flag
  localparam logic [31:0] OPT_EXP = {6'h00, 8'hff, 8'h12, 8'h3c, 1'b0, 1'b1};
  localparam logic [31:0] WP_EXP  = 32'hff00_ff0f;
  ////////////////////////////////////////////////////////////////////////////////
  // clock and reset
  logic        mclk;
  logic        rst_b;
  // wishbone
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  // information block and flash array status
  logic [1:0]  info_addr;
  logic [31:0] info_data;
  logic [15:0] rdp_pair;
  logic        target_protected;
  logic        target_erased;
  // interrupt and bank two key
  logic        irq;
  logic        bank2_key_wr;
  logic [31:0] bank2_key_data;
  // bench state
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic [31:0] seed;
  logic [31:0] ctl;
  int          bad_count;
  int          checked;
  int          cycles;
  int          b2_seen;
  int          sels[4] = '{CR_PAGE_ER, CR_MASS_ER, CR_OPT_PG, CR_OPT_ER};
  logic [31:0] pexp[3] = '{32'h0000_0010, 32'h0000_0004, 32'h0000_0020};
  ////////////////////////////////////////////////////////////////////////////////
  fper_regs #(.OP_LEN(OPL)) uut (
    .mclk             (mclk),
    .rst_b            (rst_b),
    .wb_cyc_i         (wb_cyc_i),
    .wb_stb_i         (wb_stb_i),
    .wb_we_i          (wb_we_i),
    .wb_adr_i         (wb_adr_i),
    .wb_sel_i         (wb_sel_i),
    .wb_dat_i         (wb_dat_i),
    .wb_dat_o         (wb_dat_o),
    .wb_ack_o         (wb_ack_o),
    .info_addr        (info_addr),
    .info_data        (info_data),
    .target_protected (target_protected),
    .target_erased    (target_erased),
    .irq              (irq),
    .bank2_key_wr     (bank2_key_wr),
    .bank2_key_data   (bank2_key_data)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // information block: protection pair, user 0x3c, user_byte_lo 0x12, user_byte_hi bad, wp1/wp3 erased
  always_comb begin
    case (info_addr)
      2'd0:    info_data = {rdp_pair, 16'hc33c};
      2'd1:    info_data = 32'h0034_ed12;
      2'd2:    info_data = 32'hffff_f00f;
      default: info_data = 32'hffff_ff00;
    endcase
  end
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // result watcher: oldest note against each read answer
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      `CHK(wb_dat_o, exp_v)
    end
    if (bank2_key_wr === 1'b1) b2_seen++;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic wb_cycle(input logic [7:0] adr, input logic we, input logic [31:0] dat,
                          input logic [3:0] sel);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    @(posedge mclk);
    while (wb_ack_o !== 1'b1) @(posedge mclk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_cycle
  task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_cycle(adr, 1'b1, dat, 4'hf);
  endtask : wb_wr
  task automatic wb_rd(input logic [7:0] adr, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb_cycle(adr, 1'b0, 32'h0, 4'hf);
  endtask : wb_rd
  task automatic unlock();
    wb_wr(OFF_UNLOCK_KEY, KEY_FIRST);
    wb_wr(OFF_UNLOCK_KEY, KEY_SECOND);
  endtask : unlock
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    // loader needs four edges before control writes count
    repeat (6) @(posedge mclk);
  endtask : do_reset
  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    target_protected = 1'b0;
    target_erased = 1'b1;
    seed = 32'd60;
    rdp_pair = 16'h5aa5;
    do_reset();
    // reset values, loaded images, read-only and write-only places
    wb_rd(OFF_CONTROL, RST_CONTROL);
    wb_rd(OFF_STATUS, RST_STATUS);
    wb_rd(OFF_OPTION_IMAGE, OPT_EXP);
    wb_rd(OFF_WP_IMAGE, WP_EXP);
    seed = lfsr(seed);
    wb_wr(OFF_WP_IMAGE, seed);
    wb_rd(OFF_WP_IMAGE, WP_EXP);
    wb_wr(OFF_OPTION_KEY, seed);
    wb_rd(OFF_OPTION_KEY, 32'h0);
    wb_rd(8'h30, 32'h0);
    // bank two key: full write strobes, partial write is refused
    seed = lfsr(seed);
    wb_wr(OFF_BANK2_KEY, seed);
    @(posedge mclk);
    `CHK(bank2_key_data, seed)
    wb_cycle(OFF_BANK2_KEY, 1'b1, ~seed, 4'h3);
    wb_rd(OFF_BANK2_KEY, 32'h0);
    `CHK(b2_seen, 1)
    `CHK(bank2_key_data, seed)
    // locked control ignores writes, keys open it
    wb_wr(OFF_CONTROL, CR_WRITABLE);
    wb_rd(OFF_CONTROL, RST_CONTROL);
    unlock();
    wb_rd(OFF_CONTROL, 32'h0);
    wb_wr(OFF_OPTION_KEY, KEY_FIRST);
    wb_wr(OFF_OPTION_KEY, KEY_SECOND);
    wb_rd(OFF_CONTROL, 32'h1 << CR_OPT_WREN);
    wb_wr(OFF_CONTROL, 32'h0);
    wb_rd(OFF_CONTROL, 32'h0);
    wb_wr(OFF_OPTION_KEY, KEY_FIRST);
    wb_wr(OFF_OPTION_KEY, KEY_SECOND);
    // every erase kind, done interrupt enabled
    foreach (sels[i]) begin
      ctl = (32'h1 << sels[i]) | (32'h1 << CR_OPT_WREN) | (32'h1 << CR_DONE_IE);
      wb_wr(OFF_CONTROL, ctl);
      wb_wr(OFF_CONTROL, ctl | (32'h1 << CR_START));
      wb_rd(OFF_STATUS, 32'h1 << SR_BUSY);
      repeat (OPL + 8) @(posedge mclk);
      wb_rd(OFF_STATUS, 32'h1 << SR_DONE);
      wb_rd(OFF_CONTROL, ctl);
      `CHK(irq, 1'b1)
      wb_wr(OFF_STATUS, 32'h1 << SR_DONE);
      wb_rd(OFF_STATUS, 32'h0);
      `CHK(irq, 1'b0)
    end
    // program: protected, not erased, then clean with only the error interrupt on
    for (int k = 0; k < 3; k++) begin
      target_protected <= (k == 0);
      target_erased <= (k == 2);
      ctl = (32'h1 << CR_PROGRAM) | (32'h1 << CR_ERR_IE); // start bit left clear
      wb_wr(OFF_CONTROL, ctl);
      seed = lfsr(seed);
      wb_wr(OFF_ADDRESS, seed);
      wb_wr(OFF_ADDRESS, ~seed);
      repeat (OPL + 8) @(posedge mclk);
      wb_rd(OFF_STATUS, pexp[k]);
      `CHK(irq, (k != 2))
      wb_wr(OFF_STATUS, 32'h0000_0034);
      wb_rd(OFF_STATUS, 32'h0);
      `CHK(irq, 1'b0)
    end
    // relock, a wrong key kills unlocking until a reset
    wb_wr(OFF_CONTROL, 32'h1 << CR_LOCK);
    wb_rd(OFF_CONTROL, RST_CONTROL);
    seed = lfsr(seed);
    wb_wr(OFF_UNLOCK_KEY, KEY_FIRST ^ seed);
    unlock();
    wb_rd(OFF_CONTROL, RST_CONTROL);
    rdp_pair <= 16'h1234;
    do_reset();
    wb_rd(OFF_OPTION_IMAGE, OPT_EXP | 32'h2);
    unlock();
    wb_rd(OFF_CONTROL, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
